/* File: core/aps_pkg.sv */
// constants shared by the sleep-state power sequencer and its deglitch filter
// assumes one 40 MHz clock; all pin levels arrive already digitised by comparators
// How it works
// - two active-low sleep requests move the state between active, suspend-to-ram, soft-off
// - both sleep requests are filtered so pulses under 2 us change nothing
// - no direct move between suspend-to-ram and soft-off, current state kept
// - dual-5v enable may change only in active or shutdown; sleep changes ignored
// - dual-5v enable captured on sleep entry, after por release, on shutdown exit
// - latched dual-5v enable decides if dual 5v stays powered in sleep
// - fault high on any undervoltage or overtemperature while standby is above por and no shutdown is requested
// - soft-start pin held low shuts every output off and forces fault low
// - clock-chip regulator on only in active, off in every sleep state
// - in active the main switch gate is driven on
// - in sleep the standby 5v path feeds the dual 5v rail
// - dual 3v3 standby drive on in sleep, main switch supplies it in active
// - memory rails use internal pass in sleep; in active only the 2v5 rail has an external pass drive
// - memory select: low gives 2v5, high gives 3v3, open gives both
// - standby supply watched; dual 3v3 soft-start begins once above por
// - 3 ms after dual 3v3 ramp ends, latch enable, then ramp the rest
// - 200 us after suspend request falls, enter soft-off or suspend-to-ram
// - 25 ms after main supplies are good, enable switches and clock regulator
package aps_pkg;

  // timebase
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000; // one microsecond tick

  // timing figures in their own units, counts derived from them
  localparam int unsigned GLITCH_US = 2;
  localparam int unsigned FILT_CYC = (GLITCH_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned STBY_HOLD_MS = 3;
  localparam int unsigned STBY_HOLD_US = STBY_HOLD_MS * 1000;
  localparam int unsigned MAIN_WAIT_MS = 25;
  localparam int unsigned MAIN_WAIT_US = MAIN_WAIT_MS * 1000;
  localparam int unsigned SLEEP_DLY_US = 200;
  localparam int unsigned TMR_W = 16;

  // apb register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam int unsigned CTRL_SHDN_BIT = 0;
  localparam logic CTRL_SHDN_RST = 1'b0;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_D5_BIT = 4;
  localparam int unsigned ST_M3V3_BIT = 5;
  localparam int unsigned ST_M2V5_BIT = 6;
  localparam int unsigned ST_FAULT_BIT = 7;
  localparam int unsigned ST_S3_BIT = 8;
  localparam int unsigned ST_S5_BIT = 9;

  // operating states, gray steps along start-up and active to suspend-to-ram path; soft-off entry flips two bits from sleep delay, three from standby hold
  typedef enum logic [3:0] {
    ST_POR_WAIT  = 4'h0,
    ST_STBY_RAMP = 4'h1,
    ST_STBY_HOLD = 4'h3,
    ST_MAIN_WAIT = 4'h2,
    ST_ACTIVE    = 4'h6,
    ST_SLEEP_DLY = 4'h7,
    ST_SLEEP_S3  = 4'h5,
    ST_SLEEP_S5  = 4'h4,
    ST_SHUTDOWN  = 4'hc
  } aps_state_t;

endpackage

/* File: core/aps_deglitch.sv */
// one-bit deglitch filter: output follows input only after it held steady
// assumes the input is already synchronised to pclk
module aps_deglitch
  import aps_pkg::*;
#(
  parameter int unsigned FILT = FILT_CYC,
  parameter logic INIT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic din,
  output logic dout
);

  localparam int unsigned CW = $clog2(FILT + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT - 1);

  logic [CW-1:0] cnt_reg;

  // any return to the old level restarts the count, so short pulses vanish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      dout <= INIT;
    end else if (ce) begin
      if (din == dout) begin
        cnt_reg <= '0;
      end else if (cnt_reg == LAST) begin
        cnt_reg <= '0;
        dout <= din;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

/* File: core/aps_sequencer.sv */
// sleep-state power sequencer control with apb status and control registers
// assumes pins arrive as digital comparator levels from another domain,
// rail enables drive analog switches and regulators outside this block
module aps_sequencer
  import aps_pkg::*;
#(
  parameter int unsigned UV_W = 6,
  parameter logic [7:0] P_TICK_CYC = 8'(TICK_CYC),
  parameter logic [TMR_W-1:0] P_HOLD_US = TMR_W'(STBY_HOLD_US),
  parameter logic [TMR_W-1:0] P_MAIN_US = TMR_W'(MAIN_WAIT_US),
  parameter logic [TMR_W-1:0] P_SLEEP_US = TMR_W'(SLEEP_DLY_US),
  parameter int unsigned P_FILT = FILT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins from the system and supply monitors
  input wire logic suspend_ram_request_n,
  input wire logic soft_off_request_n,
  input wire logic dual5v_sleep_support_en,
  input wire logic mem_sel_low,
  input wire logic mem_sel_high,
  input wire logic standby_por_ok,
  input wire logic standby_3v3_ramp_done,
  input wire logic main_supplies_ok,
  input wire logic soft_start_held_low,
  input wire logic over_temp,
  input wire logic [UV_W-1:0] rail_undervoltage,
  // rail controls
  output logic clock_chip_rail_en,
  output logic main_switch_gate,
  output logic standby_5v_path_ctrl,
  output logic standby_3v3_drive,
  output logic memory_2v5_ext_drive,
  output logic memory_3v3_int_en,
  output logic memory_2v5_int_en,
  output logic fault
);

  localparam int unsigned SW = UV_W + 10;
  // sleep requests idle high so reset does not look like a request
  localparam logic [SW-1:0] SYNC_RST = {2'b11, {(SW - 2) {1'b0}}};

  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic s3_f;
  logic s5_f;
  logic [7:0] presc_reg;
  logic [TMR_W-1:0] timer_reg;
  aps_state_t state_reg;
  aps_state_t state_next;
  logic d5_lat_reg;
  logic m3v3_lat_reg;
  logic m2v5_lat_reg;
  logic ctrl_shdn_reg;

  // two-flop synchronisers for every pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else if (ce) begin
      sync1_reg <= {suspend_ram_request_n, soft_off_request_n, dual5v_sleep_support_en,
                    mem_sel_low, mem_sel_high, standby_por_ok, standby_3v3_ramp_done,
                    main_supplies_ok, soft_start_held_low, over_temp, rail_undervoltage};
      sync2_reg <= sync1_reg;
    end
  end

  wire s3_s = sync2_reg[SW-1];
  wire s5_s = sync2_reg[SW-2];
  wire d5_s = sync2_reg[SW-3];
  wire sel_lo_s = sync2_reg[SW-4];
  wire sel_hi_s = sync2_reg[SW-5];
  wire por_s = sync2_reg[SW-6];
  wire ramp_s = sync2_reg[SW-7];
  wire main_s = sync2_reg[SW-8];
  wire ss_s = sync2_reg[SW-9];
  wire ot_s = sync2_reg[SW-10];
  wire [UV_W-1:0] uv_s = sync2_reg[UV_W-1:0];

  // sleep request deglitch filters
  aps_deglitch #(.FILT(P_FILT), .INIT(1'b1)) u_flt_s3 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(s3_s),
    .dout(s3_f)
  );

  aps_deglitch #(.FILT(P_FILT), .INIT(1'b1)) u_flt_s5 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(s5_s),
    .dout(s5_f)
  );

  // free-running microsecond tick; no clock pin exists on the real part
  wire tick = (presc_reg == P_TICK_CYC - 8'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= 8'h00;
    end else if (ce) begin
      presc_reg <= tick ? 8'h00 : presc_reg + 8'h01;
    end
  end

  // shutdown from the soft-start pin or from software
  wire shut = ss_s | ctrl_shdn_reg;
  wire hold_done = (timer_reg >= P_HOLD_US);
  wire main_done = (timer_reg >= P_MAIN_US);
  wire sleep_done = (timer_reg >= P_SLEEP_US);
  wire pick_s5 = ~s5_f;

  // state decode
  always_comb begin
    state_next = state_reg;
    if (!por_s) begin
      state_next = ST_POR_WAIT;
    end else if (shut) begin
      state_next = ST_SHUTDOWN;
    end else begin
      unique case (state_reg)
        ST_POR_WAIT: state_next = ST_STBY_RAMP;
        ST_SHUTDOWN: state_next = ST_STBY_RAMP;
        ST_STBY_RAMP: begin
          if (ramp_s) begin
            state_next = ST_STBY_HOLD;
          end
        end
        ST_STBY_HOLD: begin
          if (hold_done) begin
            if (!s3_f) begin
              state_next = pick_s5 ? ST_SLEEP_S5 : ST_SLEEP_S3;
            end else begin
              state_next = ST_MAIN_WAIT;
            end
          end
        end
        ST_MAIN_WAIT: begin
          if (!s3_f) begin
            state_next = ST_SLEEP_DLY;
          end else if (main_done) begin
            state_next = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (!s3_f) begin
            state_next = ST_SLEEP_DLY;
          end
        end
        ST_SLEEP_DLY: begin
          if (s3_f) begin
            state_next = ST_MAIN_WAIT;
          end else if (sleep_done) begin
            state_next = pick_s5 ? ST_SLEEP_S5 : ST_SLEEP_S3;
          end
        end
        // only both requests high wakes; other sleep pairings hold the state
        ST_SLEEP_S3, ST_SLEEP_S5: begin
          if (s3_f && s5_f) begin
            state_next = ST_MAIN_WAIT;
          end
        end
        default: state_next = ST_POR_WAIT;
      endcase
    end
  end

  // state timer restarts on each state change and, in main wait, while mains are not good
  wire moving = (state_next != state_reg);
  wire tmr_clr = moving | (state_reg == ST_MAIN_WAIT & ~main_s);
  wire tmr_sat = (timer_reg == {TMR_W{1'b1}});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_POR_WAIT;
      timer_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      if (tmr_clr) begin
        timer_reg <= '0;
      end else if (tick && !tmr_sat) begin
        timer_reg <= timer_reg + 1'b1;
      end
    end
  end

  // enable and memory select captured only at start-up end and sleep entry
  wire next_sleep = (state_next == ST_SLEEP_S3) | (state_next == ST_SLEEP_S5);
  wire latch_evt = moving & ((state_reg == ST_STBY_HOLD) | next_sleep);
  wire d5_next = latch_evt ? d5_s : d5_lat_reg;
  wire m3v3_next = latch_evt ? ~sel_lo_s : m3v3_lat_reg;
  wire m2v5_next = latch_evt ? ~sel_hi_s : m2v5_lat_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d5_lat_reg <= 1'b0;
      m3v3_lat_reg <= 1'b0;
      m2v5_lat_reg <= 1'b0;
    end else if (ce) begin
      d5_lat_reg <= d5_next;
      m3v3_lat_reg <= m3v3_next;
      m2v5_lat_reg <= m2v5_next;
    end
  end

  // rail controls follow the next state so they line up with state_reg
  wire act_next = (state_next == ST_ACTIVE);
  wire off_next = (state_next == ST_POR_WAIT) | (state_next == ST_SHUTDOWN);
  wire fault_next = por_s & ~shut & ((|uv_s) | ot_s);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_chip_rail_en <= 1'b0;
      main_switch_gate <= 1'b0;
      standby_5v_path_ctrl <= 1'b0;
      standby_3v3_drive <= 1'b0;
      memory_2v5_ext_drive <= 1'b0;
      memory_3v3_int_en <= 1'b0;
      memory_2v5_int_en <= 1'b0;
      fault <= 1'b0;
    end else if (ce) begin
      clock_chip_rail_en <= act_next;
      main_switch_gate <= act_next;
      standby_5v_path_ctrl <= next_sleep & d5_next;
      standby_3v3_drive <= ~off_next & ~act_next;
      memory_2v5_ext_drive <= act_next & m2v5_next;
      memory_3v3_int_en <= next_sleep & m3v3_next;
      memory_2v5_int_en <= next_sleep & m2v5_next;
      fault <= fault_next;
    end
  end

  // apb slave: one wait state, answer registered so outputs come from flops
  wire acc = psel & penable & ~pready;
  wire hit_ctrl = (paddr == CTRL_OFS);
  wire hit_stat = (paddr == STATUS_OFS);
  wire wr_done = psel & penable & pready & pwrite & hit_ctrl;
  wire [31:0] status_word = {22'h000000, s5_f, s3_f, fault, m2v5_lat_reg, m3v3_lat_reg,
                             d5_lat_reg, state_reg};
  wire [31:0] rd_word = hit_ctrl ? {31'h00000000, ctrl_shdn_reg} :
                        hit_stat ? status_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_shdn_reg <= CTRL_SHDN_RST;
    end else if (ce) begin
      pready <= acc;
      pslverr <= acc & ~(hit_ctrl | hit_stat);
      prdata <= (acc && !pwrite) ? rd_word : 32'h00000000;
      if (wr_done) begin
        ctrl_shdn_reg <= pwdata[CTRL_SHDN_BIT];
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire in_sleep = (state_reg == ST_SLEEP_S3) | (state_reg == ST_SLEEP_S5);

  property p_clk_rail;
    clock_chip_rail_en |-> state_reg == ST_ACTIVE && !in_sleep;
  endproperty
  a_clk_rail: assert property (p_clk_rail) else $error("clock rail on outside active");

  property p_no_s3_s5;
    ce && state_reg == ST_SLEEP_S3 |=> state_reg != ST_SLEEP_S5;
  endproperty
  a_no_s3_s5: assert property (p_no_s3_s5) else $error("direct s3 to s5 move");

  property p_no_s5_s3;
    ce && state_reg == ST_SLEEP_S5 |=> state_reg != ST_SLEEP_S3;
  endproperty
  a_no_s5_s3: assert property (p_no_s5_s3) else $error("direct s5 to s3 move");

  property p_shutdown;
    ce && por_s && ss_s |=> !fault && !main_switch_gate && !standby_3v3_drive
      && !clock_chip_rail_en && state_reg == ST_SHUTDOWN;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("soft-start low did not shut down");

  property p_por_low;
    ce && !por_s |=> state_reg == ST_POR_WAIT && !fault && !standby_3v3_drive;
  endproperty
  a_por_low: assert property (p_por_low) else $error("outputs alive below por");

  property p_fault;
    ce && por_s && !shut && (ot_s || (|uv_s)) |=> fault;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not raised");

  property p_sleep_pick;
    ce && por_s && !shut && state_reg == ST_SLEEP_DLY && sleep_done && !s3_f
      |=> (state_reg == ST_SLEEP_S5) == !$past(s5_f);
  endproperty
  a_sleep_pick: assert property (p_sleep_pick) else $error("wrong sleep state chosen");

  property p_d5_path;
    standby_5v_path_ctrl |-> in_sleep && d5_lat_reg;
  endproperty
  a_d5_path: assert property (p_d5_path) else $error("5v path on without latched enable");

  property p_d5_hold;
    ce && in_sleep && state_next == state_reg |=> $stable(d5_lat_reg);
  endproperty
  a_d5_hold: assert property (p_d5_hold) else $error("enable relatched during sleep");

  property p_switch_3v3;
    (main_switch_gate == (state_reg == ST_ACTIVE)) && !(main_switch_gate && standby_3v3_drive);
  endproperty
  a_switch_3v3: assert property (p_switch_3v3) else $error("switch and 3v3 drive clash");

  property p_active_entry;
    $rose(state_reg == ST_ACTIVE) |-> $past(state_reg) == ST_MAIN_WAIT && $past(main_done);
  endproperty
  a_active_entry: assert property (p_active_entry) else $error("active entered early");

  c_active: cover property (state_reg == ST_ACTIVE);
  c_s3: cover property ($past(state_reg) == ST_ACTIVE ##[1:1000] state_reg == ST_SLEEP_S3);
  c_s5: cover property (state_reg == ST_SLEEP_S5);
  c_shdn: cover property (state_reg == ST_SHUTDOWN);

endmodule

/* File: sim/aps_supply_model.sv */
// supply-side partner: standby and main atx rails as the sequencer sees them
// assumes the bench switches the supplies through stby_on and atx_on
module aps_supply_model #(
  parameter int unsigned RAMP_CYC = 6,
  parameter int unsigned MAIN_CYC = 4
) (
  input wire logic pclk,
  input wire logic stby_on,
  input wire logic atx_on,
  input wire logic standby_3v3_drive,
  output logic standby_por_ok,
  output logic standby_3v3_ramp_done,
  output logic main_supplies_ok
);
  timeunit 1ns;
  timeprecision 100ps;
  int ramp_cnt = 0;
  int main_cnt = 0;

  // ramp and main rails need a few cycles to settle; standby por follows stby_on at once
  always @(posedge pclk) begin
    ramp_cnt <= (stby_on && standby_3v3_drive) ? ramp_cnt + 1 : 0;
    main_cnt <= atx_on ? main_cnt + 1 : 0;
  end

  // the standby ramp only finishes while the sequencer drives the standby regulator
  assign standby_por_ok = stby_on;
  assign standby_3v3_ramp_done = (ramp_cnt >= RAMP_CYC);
  assign main_supplies_ok = (main_cnt >= MAIN_CYC);
endmodule

/* File: sim/test_acpi_sleep_state_power_sequencer.sv */
// bench for the sleep-state power sequencer: apb tasks plus pin-level scenarios
// assumes the shortened timer parameters below and the supply model beside it
module test_acpi_sleep_state_power_sequencer
  import aps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic ce = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic suspend_ram_request_n = 1'h1;
  logic soft_off_request_n = 1'h1;
  logic dual5v_sleep_support_en = 1'h1;
  logic mem_sel_low = 1'h0;
  logic mem_sel_high = 1'h0;
  logic soft_start_held_low = 1'h0;
  logic over_temp = 1'h0;
  logic [5:0] rail_undervoltage = 6'h01;
  logic stby_on = 1'h0;
  logic atx_on = 1'h0;
  logic standby_por_ok, standby_3v3_ramp_done, main_supplies_ok;
  logic clock_chip_rail_en, main_switch_gate, standby_5v_path_ctrl, standby_3v3_drive;
  logic memory_2v5_ext_drive, memory_3v3_int_en, memory_2v5_int_en, fault;
  logic [7:0] rails;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_tests = 0;
  int i;

  always #12.5 pclk = ~pclk;

  // all rail controls in one vector so one compare covers a whole state
  assign rails = {clock_chip_rail_en, main_switch_gate, standby_5v_path_ctrl,
    standby_3v3_drive, memory_2v5_ext_drive, memory_3v3_int_en, memory_2v5_int_en, fault};

  aps_sequencer #(.P_TICK_CYC(8'h02), .P_HOLD_US(16'h0005), .P_MAIN_US(16'h000a),
    .P_SLEEP_US(16'h0004), .P_FILT(4)) i_aps_sequencer (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .suspend_ram_request_n, .soft_off_request_n,
    .dual5v_sleep_support_en, .mem_sel_low, .mem_sel_high, .standby_por_ok,
    .standby_3v3_ramp_done, .main_supplies_ok, .soft_start_held_low, .over_temp,
    .rail_undervoltage, .clock_chip_rail_en, .main_switch_gate, .standby_5v_path_ctrl,
    .standby_3v3_drive, .memory_2v5_ext_drive, .memory_3v3_int_en, .memory_2v5_int_en,
    .fault);

  aps_supply_model i_aps_supply_model (
    .pclk, .stby_on, .atx_on, .standby_3v3_drive, .standby_por_ok,
    .standby_3v3_ramp_done, .main_supplies_ok);

  task automatic print_verdict();
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 40; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k == 40) begin
      chk("pready", 1'h1, 1'h0);
      print_verdict();
    end
  endtask

  // poll status until the state code shows; a bounded poll, never open-ended
  task automatic state_is(input logic [3:0] code);
    int k;
    for (k = 0; k < 200; k++) begin
      apb(1'h0, STATUS_OFS, 32'h0);
      if (rd[3:0] === code) break;
    end
    chk("state", code, rd[3:0]);
    if (k == 200) print_verdict();
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, CTRL_OFS, 32'h0);
    chk("ctrl", 32'h0, rd);
    state_is(4'h0);
    chk("rails", 8'h00, rails);
    rail_undervoltage <= 6'h00;
    stby_on <= 1'h1;
    state_is(4'h2);
    chk("latched", 3'h7, rd[6:4]);
    repeat (40) @(posedge pclk);
    chk("rails", 8'h10, rails);
    atx_on <= 1'h1;
    state_is(4'h6);
    chk("rails", 8'hc8, rails);
    // a two-cycle pulse is shorter than the filter and must not leave active
    suspend_ram_request_n <= 1'h0;
    repeat (2) @(posedge pclk);
    suspend_ram_request_n <= 1'h1;
    repeat (30) @(posedge pclk);
    apb(1'h0, STATUS_OFS, 32'h0);
    chk("state", 4'h6, rd[3:0]);
    dual5v_sleep_support_en <= 1'h0;
    mem_sel_low <= 1'h1;
    suspend_ram_request_n <= 1'h0;
    state_is(4'h5);
    chk("rails", 8'h12, rails);
    atx_on <= 1'h0;
    dual5v_sleep_support_en <= 1'h1;
    repeat (20) @(posedge pclk);
    soft_off_request_n <= 1'h0;
    repeat (40) @(posedge pclk);
    apb(1'h0, STATUS_OFS, 32'h0);
    chk("state", 4'h5, rd[3:0]);
    chk("latched en", 1'h0, rd[4]);
    chk("rails", 8'h12, rails);
    soft_off_request_n <= 1'h1;
    repeat (10) @(posedge pclk);
    suspend_ram_request_n <= 1'h1;
    atx_on <= 1'h1;
    state_is(4'h6);
    mem_sel_low <= 1'h0;
    mem_sel_high <= 1'h1;
    suspend_ram_request_n <= 1'h0;
    soft_off_request_n <= 1'h0;
    state_is(4'h4);
    chk("rails", 8'h34, rails);
    soft_off_request_n <= 1'h1;
    suspend_ram_request_n <= 1'h1;
    state_is(4'h6);
    // every undervoltage input on its own, then overtemperature
    for (i = 0; i < 6; i++) begin
      rail_undervoltage <= 6'h01 << i;
      repeat (6) @(posedge pclk);
      chk("fault", 1'h1, fault);
      rail_undervoltage <= 6'h00;
      repeat (6) @(posedge pclk);
      chk("fault", 1'h0, fault);
    end
    // clock enable low freezes every sequencer flop, so the fault flag must not follow yet
    ce <= 1'h0;
    over_temp <= 1'h1;
    repeat (6) @(posedge pclk);
    chk("frozen fault", 1'h0, fault);
    ce <= 1'h1;
    repeat (6) @(posedge pclk);
    chk("fault", 1'h1, fault);
    apb(1'h1, CTRL_OFS, 32'h1);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1, rd);
    state_is(4'hc);
    chk("rails", 8'h00, rails);
    over_temp <= 1'h0;
    dual5v_sleep_support_en <= 1'h0;
    apb(1'h1, CTRL_OFS, 32'h0);
    state_is(4'h6);
    chk("latched en", 1'h0, rd[4]);
    soft_start_held_low <= 1'h1;
    state_is(4'hc);
    chk("rails", 8'h00, rails);
    soft_start_held_low <= 1'h0;
    state_is(4'h6);
    // unmapped address and a write to the read-only status word
    apb(1'h0, 8'h08, 32'h0);
    chk("pslverr", 1'h1, err);
    chk("prdata", 32'h0, rd);
    apb(1'h1, STATUS_OFS, 32'hffff_ffff);
    chk("pslverr", 1'h0, err);
    apb(1'h0, STATUS_OFS, 32'h0);
    chk("state", 4'h6, rd[3:0]);
    stby_on <= 1'h0;
    state_is(4'h0);
    chk("rails", 8'h00, rails);
    print_verdict();
  end
endmodule
